//--- hw/oss_ctrl.sv
// Purpose: Oscillator group selection and clock switch control
// Assumes: rst stands for power-on or brown-out reset; clk is 25 MHz
// Notes:   Oscillators, PLL and fail monitor sit outside this block
//
// How it works
// - current_group field is read only and reports the live group code
// - reset loads current_group and new_group from powerup_group_config
// - a completed switch copies new_group into current_group
// - a monitor failure sets current_group to the fast RC code
// - clock_divider_select divides by 1, 4, 16 or 64
// - lock flag clears on reset, switch start and loss; sets on lock
// - lock flag reads zero unless the PLL group is live
// - clock_fail_flag sets on failure, clears on reset, start, software
// - secondary_osc_enable drives the secondary oscillator; reset clears
// - software sets switch_request to ask for a switch to new_group
// - switch_request clears on reset, success, redundant switch, failure
// - unimplemented control and tuning bits read as zero
// - four-bit signed rc_trim_code steers the fast RC oscillator
// - switch_monitor_config 1x off, 01 switching only, 00 both on
// - power-up group comes from the configuration word group field
// - primary option, PLL source included, comes from configuration
// - startup check after timers traps to fast RC if clock is unready
// - no monitor and no power-up timer gives a fast reset exit
// - no monitor and no system clock keeps the core halted
// - power-on reset selects the source from configuration
// - clearing switch_request aborts a switch in progress
// - switching moves between groups only, never options inside one
//
// Implementation choices: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps

module oss_ctrl (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Avalon-MM slave
	input  wire logic [3:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	// Programmed configuration word
	input  wire logic [23:0] cfg_word_in,
	// Status from the oscillators, monitor and reset unit
	input  wire logic        clk_fail_in,
	input  wire logic        osc_running_in,
	input  wire logic        ost_expired_in,
	input  wire logic        pll_locked_in,
	input  wire logic        timers_done_in,
	input  wire logic        power_up_timer_disabled_in,
	input  wire logic        sysclk_running_in,
	input  wire logic        switch_done_in,
	// Oscillator steering
	output logic      [2:0]  current_group,
	output logic      [2:0]  target_group,
	output logic             switch_active,
	output logic      [3:0]  primary_option_config,
	output logic      [3:0]  rc_trim_code,
	output logic             secondary_osc_enable,
	output logic             fail_safe_monitor,
	output logic             switch_allowed,
	output logic             div_tick,
	// Core control
	output logic             clock_fail_trap,
	output logic             core_run
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------

	// Last count of the postscaler for a given code
	function automatic logic [5:0] div_last(input logic [1:0] sel);
		case (sel)
			oss_pkg::POST_D1:  div_last = oss_pkg::LAST_D1;
			oss_pkg::POST_D4:  div_last = oss_pkg::LAST_D4;
			oss_pkg::POST_D16: div_last = oss_pkg::LAST_D16;
			default:           div_last = oss_pkg::LAST_D64;
		endcase
	endfunction : div_last

	// Advance one lane's unlock sequence on a completed access
	function automatic oss_pkg::oss_key_t key_step(
		input oss_pkg::oss_key_t key,
		input logic              lane_wr,
		input logic [7:0]        data,
		input logic [7:0]        k1,
		input logic [7:0]        k2
	);
		key_step = oss_pkg::KEY_IDLE;
		if (lane_wr && key == oss_pkg::KEY_FIRST && data == k2) begin
			key_step = oss_pkg::KEY_OPEN;
		end else if (lane_wr && key == oss_pkg::KEY_IDLE && data == k1) begin
			key_step = oss_pkg::KEY_FIRST;
		end
	endfunction : key_step

	// ----------------------------------------------------------------
	// State and decoded events
	// ----------------------------------------------------------------
	oss_pkg::oss_state_t     st;
	oss_pkg::oss_state_t     st_next;
	logic [oss_pkg::NSYNC-1:0] pins;
	logic [oss_pkg::NSYNC-1:0] f_new;
	logic [oss_pkg::NSYNC-1:0] rise;
	logic [1:0]              cksm;
	logic                    sw_en;
	logic                    mon_en;
	logic                    req;
	logic                    done_bus;
	logic                    fail_ev;
	logic                    done_ev;
	logic                    start_ev;
	logic                    redund_ev;
	logic                    unready;
	logic                    lock_vis;
	logic [31:0]             rd_mux;

	assign pins = {switch_done_in, sysclk_running_in, power_up_timer_disabled_in,
	               timers_done_in, pll_locked_in, ost_expired_in,
	               osc_running_in, clk_fail_in};

	// A pin change counts once the second and third stages agree
	assign f_new = (st.s2 ~^ st.s3) & st.s3 | (st.s2 ^ st.s3) & st.flt;
	assign rise  = f_new & ~st.flt;

	// Configuration decode: upper bit kills both functions
	assign cksm   = st.cfg[oss_pkg::CKSM_LSB +: 2];
	assign sw_en  = ~cksm[1];
	assign mon_en = ~cksm[1] & ~cksm[0];

	assign req      = read | write;
	assign done_bus = req & ~st.wait_r;

	// Clock is unready after the timers: dead, unsettled or unlocked
	assign unready  = ~f_new[oss_pkg::IN_RUN] | ~f_new[oss_pkg::IN_OST] |
	                  (st.cur == oss_pkg::GRP_PLL &
	                   ~f_new[oss_pkg::IN_LOCK]);
	// Monitor trips either on a live failure or on the startup check
	assign fail_ev  = mon_en & (rise[oss_pkg::IN_FAIL] |
	                  (~st.chk_done & f_new[oss_pkg::IN_TMR] &
	                   unready));
	assign done_ev  = st.busy & st.req & rise[oss_pkg::IN_DONE] & ~fail_ev;
	assign start_ev = st.req & ~st.busy & sw_en & ~fail_ev &
	                  (st.nw != st.cur);
	assign redund_ev = st.req & ~st.busy & sw_en & ~fail_ev &
	                   (st.nw == st.cur);
	assign lock_vis = st.lock & (st.cur == oss_pkg::GRP_PLL);

	// ----------------------------------------------------------------
	// Read multiplexer
	// ----------------------------------------------------------------

	// Unimplemented bits keep the zero default of rd_mux
	always_comb begin
		rd_mux = 32'h0;
		case (address)
			oss_pkg::ADDR_CTRL: begin
				rd_mux[oss_pkg::CUR_LSB +: 3]  = st.cur;
				rd_mux[oss_pkg::NEW_LSB +: 3]  = st.nw;
				rd_mux[oss_pkg::POST_LSB +: 2] = st.post;
				rd_mux[oss_pkg::LOCK_BIT]      = lock_vis;
				rd_mux[oss_pkg::CF_BIT]        = st.cf;
				rd_mux[oss_pkg::SEC_BIT]       = st.sec_en;
				rd_mux[oss_pkg::REQ_BIT]       = st.req;
			end
			oss_pkg::ADDR_TUNE: begin
				rd_mux[3:0] = st.trim;
			end
			oss_pkg::ADDR_CFG: begin
				rd_mux[23:0] = st.cfg & oss_pkg::CFG_MASK;
			end
			default: begin
				rd_mux = 32'h0;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------

	// Software effects go first so that hardware events override them
	always_comb begin
		st_next = st;
		// Pin synchronisers
		st_next.s1  = pins;
		st_next.s2  = st.s1;
		st_next.s3  = st.s2;
		st_next.flt = f_new;

		// Bus handshake: one wait cycle, then the transfer completes
		if (req && st.wait_r) begin
			st_next.wait_r = 1'b0;
			st_next.rdata  = read ? rd_mux : 32'h0;
		end else begin
			st_next.wait_r = 1'b1;
		end

		if (done_bus) begin
			// Any other access breaks a started unlock sequence
			st_next.key_lo = key_step(st.key_lo,
				write && address == oss_pkg::ADDR_CTRL && byteenable[0],
				writedata[7:0], oss_pkg::KEY_LO_1,
				oss_pkg::KEY_LO_2);
			st_next.key_hi = key_step(st.key_hi,
				write && address == oss_pkg::ADDR_CTRL && byteenable[1],
				writedata[15:8], oss_pkg::KEY_HI_1,
				oss_pkg::KEY_HI_2);
			if (write && address == oss_pkg::ADDR_CTRL) begin
				if (byteenable[0] && st.key_lo == oss_pkg::KEY_OPEN) begin
					st_next.post   = writedata[oss_pkg::POST_LSB +: 2];
					st_next.sec_en = writedata[oss_pkg::SEC_BIT];
					st_next.req    = writedata[oss_pkg::REQ_BIT];
					// Software can only clear the flag, never set it
					st_next.cf     = st.cf & writedata[oss_pkg::CF_BIT];
					st_next.key_lo = oss_pkg::KEY_IDLE;
				end
				if (byteenable[1] && st.key_hi == oss_pkg::KEY_OPEN) begin
					st_next.nw     = writedata[oss_pkg::NEW_LSB +: 3];
					st_next.key_hi = oss_pkg::KEY_IDLE;
				end
			end
			if (write && address == oss_pkg::ADDR_TUNE && byteenable[0]) begin
				st_next.trim = writedata[3:0];
			end
		end

		// Lock follows the PLL, dropped when a new sequence starts
		st_next.lock = f_new[oss_pkg::IN_LOCK] & ~start_ev;

		// Switch sequencing; a failure takes every other path over
		if (fail_ev) begin
			st_next.cur  = oss_pkg::GRP_FRC;
			st_next.cf   = 1'b1;
			st_next.req  = 1'b0;
			st_next.busy = 1'b0;
		end else if (done_ev) begin
			st_next.cur  = st.nw;
			st_next.req  = 1'b0;
			st_next.busy = 1'b0;
		end else if (st.busy && !st.req) begin
			st_next.busy = 1'b0;
		end else if (start_ev) begin
			st_next.busy = 1'b1;
			st_next.cf   = 1'b0;
		end else if (redund_ev) begin
			st_next.req  = 1'b0;
		end
		if (f_new[oss_pkg::IN_TMR]) begin
			st_next.chk_done = 1'b1;
		end

		// Postscaler: one tick per divided period
		if (st.div_cnt >= div_last(st.post)) begin
			st_next.div_cnt  = 6'h00;
			st_next.div_tick = 1'b1;
		end else begin
			st_next.div_cnt  = st.div_cnt + 6'h01;
			st_next.div_tick = 1'b0;
		end

		st_next.trap = fail_ev;
		// Release: timers done, or at once without monitor and timer;
		// without monitor the core waits for a running system clock
		st_next.core_run = (f_new[oss_pkg::IN_TMR] |
		                    (~mon_en & f_new[oss_pkg::IN_NOPWRT])) &
		                   (mon_en | f_new[oss_pkg::IN_SYSCLK]);

		if (rst) begin
			st_next          = '0;
			st_next.cfg      = cfg_word_in;
			st_next.cur      = cfg_word_in[oss_pkg::FOS_LSB +: 3];
			st_next.nw       = cfg_word_in[oss_pkg::FOS_LSB +: 3];
			st_next.mon_on   = ~|cfg_word_in[oss_pkg::CKSM_LSB +: 2];
			st_next.sw_on    = ~cfg_word_in[oss_pkg::CKSM_LSB + 1];
			st_next.wait_r   = 1'b1;
		end
	end

	// State register; the strap is caught by this clocked process
	always_ff @(posedge clk) begin
		st <= st_next;
	end

	// ----------------------------------------------------------------
	// Outputs, each straight from the state word
	// ----------------------------------------------------------------
	assign readdata              = st.rdata;
	assign waitrequest           = st.wait_r;
	assign current_group         = st.cur;
	assign target_group          = st.nw;
	assign switch_active         = st.busy;
	assign primary_option_config = st.cfg[oss_pkg::FPR_LSB +: 4];
	assign rc_trim_code          = st.trim;
	assign secondary_osc_enable  = st.sec_en;
	assign fail_safe_monitor     = st.mon_on;
	assign switch_allowed        = st.sw_on;
	assign div_tick              = st.div_tick;
	assign clock_fail_trap       = st.trap;
	assign core_run              = st.core_run;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_cur_read;
		!st.wait_r && read && $past(address) == oss_pkg::ADDR_CTRL |->
			readdata[14:12] == $past(st.cur) && readdata[15] == 1'b0 &&
			readdata[11] == 1'b0 && readdata[4] == 1'b0 &&
			readdata[2] == 1'b0;
	endproperty
	a_cur_read: assert property (p_cur_read)
		else $error("control read shows wrong group or reserved bits");

	property p_reset_load;
		@(posedge clk) rst ##1 rst |=> !rst |-> st.cur ==
			$past(cfg_word_in[10:8]) && st.nw == st.cur;
	endproperty
	a_reset_load: assert property (disable iff (1'b0) p_reset_load)
		else $error("reset did not load the power-up group");

	property p_switch_done;
		done_ev |=> st.cur == $past(st.nw) && !st.req && !st.busy;
	endproperty
	a_switch_done: assert property (p_switch_done)
		else $error("completed switch did not update current group");

	property p_fail;
		fail_ev |=> st.cur == oss_pkg::GRP_FRC && st.cf && !st.req &&
			clock_fail_trap ##1 !clock_fail_trap || $past(fail_ev);
	endproperty
	a_fail: assert property (p_fail)
		else $error("failure did not force fast RC and set the flag");

	property p_div;
		div_tick |->
			$past(st.div_cnt) >= div_last($past(st.post));
	endproperty
	a_div: assert property (p_div)
		else $error("postscaler ticked at the wrong count");

	property p_lock_start;
		start_ev |=> !st.lock ##1 st.busy || !st.req || fail_ev;
	endproperty
	a_lock_start: assert property (p_lock_start)
		else $error("lock flag not cleared at switch start");

	property p_lock_hidden;
		!st.wait_r && read && $past(address) == oss_pkg::ADDR_CTRL &&
			$past(st.cur) != oss_pkg::GRP_PLL |-> readdata[5] == 1'b0;
	endproperty
	a_lock_hidden: assert property (p_lock_hidden)
		else $error("lock flag visible while PLL not selected");

	property p_redundant;
		redund_ev |=> !st.req && !st.busy && st.cur == $past(st.cur);
	endproperty
	a_redundant: assert property (p_redundant)
		else $error("redundant switch left the request set");

	property p_abort;
		st.busy && !st.req && !fail_ev |=> !st.busy && !switch_active;
	endproperty
	a_abort: assert property (p_abort)
		else $error("clearing the request did not abort the switch");

	property p_no_switch;
		!sw_en |-> !st.busy && !switch_allowed;
	endproperty
	a_no_switch: assert property (p_no_switch)
		else $error("switch started while switching is disabled");

	property p_halt;
		!mon_en && !f_new[oss_pkg::IN_SYSCLK] |=> !core_run;
	endproperty
	a_halt: assert property (p_halt)
		else $error("core released without a system clock");

	property p_bus;
		req && st.wait_r |=> !waitrequest ##1 waitrequest;
	endproperty
	a_bus: assert property (p_bus)
		else $error("bus answer not given after one wait cycle");

	c_switch: cover property (start_ev ##[1:200] done_ev);
	c_fail:   cover property (fail_ev);
	c_redund: cover property (redund_ev);
	c_unlock: cover property (st.key_lo == oss_pkg::KEY_OPEN);

endmodule : oss_ctrl

//--- hw/oss_pkg.sv
// Purpose: Shared constants and types for the oscillator select block
// Assumes: Avalon-MM byte addresses, one 32-bit word per register
// Notes:   Group codes are shared by the live, new and power-up fields
package oss_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [3:0]  ADDR_CTRL = 4'h0; // oscillator_control
	localparam logic [3:0]  ADDR_TUNE = 4'h4; // rc_tuning
	localparam logic [3:0]  ADDR_CFG  = 4'h8; // oscillator_config_word

	// ----------------------------------------------------------------
	// Oscillator group codes
	// ----------------------------------------------------------------
	localparam logic [2:0]  GRP_PLL   = 3'h7;
	localparam logic [2:0]  GRP_EXT   = 3'h3;
	localparam logic [2:0]  GRP_LOW_POWER_RC_OSCILLATOR  = 3'h2;
	localparam logic [2:0]  GRP_FRC   = 3'h1;
	localparam logic [2:0]  GRP_LPXT  = 3'h0;

	// ----------------------------------------------------------------
	// Control register fields
	// ----------------------------------------------------------------
	localparam int          CUR_LSB   = 12;
	localparam int          NEW_LSB   = 8;
	localparam int          POST_LSB  = 6;
	localparam int          LOCK_BIT  = 5;
	localparam int          CF_BIT    = 3;
	localparam int          SEC_BIT   = 1;
	localparam int          REQ_BIT   = 0;
	localparam logic [7:0]  KEY_LO_1  = 8'h46;
	localparam logic [7:0]  KEY_LO_2  = 8'h57;
	localparam logic [7:0]  KEY_HI_1  = 8'h78;
	localparam logic [7:0]  KEY_HI_2  = 8'h9a;

	// ----------------------------------------------------------------
	// Configuration word fields
	// ----------------------------------------------------------------
	localparam int          CKSM_LSB  = 14;
	localparam int          FOS_LSB   = 8;
	localparam int          FPR_LSB   = 0;
	localparam logic [23:0] CFG_MASK  = 24'h00c70f;

	// ----------------------------------------------------------------
	// Postscaler codes and last count of each division
	// ----------------------------------------------------------------
	localparam logic [1:0]  POST_D1   = 2'h0;
	localparam logic [1:0]  POST_D4   = 2'h1;
	localparam logic [1:0]  POST_D16  = 2'h2;
	localparam logic [5:0]  LAST_D1   = 6'h00;
	localparam logic [5:0]  LAST_D4   = 6'h03;
	localparam logic [5:0]  LAST_D16  = 6'h0f;
	localparam logic [5:0]  LAST_D64  = 6'h3f;

	// ----------------------------------------------------------------
	// Indices of the pin inputs inside the synchroniser vector
	// ----------------------------------------------------------------
	localparam int          NSYNC     = 8;
	localparam int          IN_FAIL   = 0; // Monitor saw a dead clock
	localparam int          IN_RUN    = 1; // Oscillator oscillates
	localparam int          IN_OST    = 2; // Start-up timer expired
	localparam int          IN_LOCK   = 3; // PLL in lock
	localparam int          IN_TMR    = 4; // Power-up timers expired
	localparam int          IN_NOPWRT = 5; // Power-up timer disabled
	localparam int          IN_SYSCLK = 6; // System clock running
	localparam int          IN_DONE   = 7; // Oscillator switch finished

	// Unlock sequence progress of one byte lane
	typedef enum logic [1:0] {
		KEY_IDLE  = 2'b00,
		KEY_FIRST = 2'b01,
		KEY_OPEN  = 2'b10
	} oss_key_t;

	// Whole state of the block, registered as one word
	typedef struct packed {
		logic [NSYNC-1:0] s1;
		logic [NSYNC-1:0] s2;
		logic [NSYNC-1:0] s3;
		logic [NSYNC-1:0] flt;
		logic [23:0]      cfg;
		logic [2:0]       cur;
		logic [2:0]       nw;
		logic [1:0]       post;
		logic             lock;
		logic             cf;
		logic             sec_en;
		logic             req;
		logic             busy;
		logic             chk_done;
		logic [3:0]       trim;
		oss_key_t         key_lo;
		oss_key_t         key_hi;
		logic             wait_r;
		logic [31:0]      rdata;
		logic [5:0]       div_cnt;
		logic             div_tick;
		logic             trap;
		logic             core_run;
		logic             mon_on;
		logic             sw_on;
	} oss_state_t;

endpackage : oss_pkg

//--- sim/oss_ctrl_test.sv
// Purpose: Self-checking bench for the clock switch control block
// Assumes: oss_osc_model plays the oscillators and the PLL
// Notes:   Avalon master waits for waitrequest low under a cycle cap
`timescale 1ns/1ps
module oss_ctrl_test;
	logic        clk = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0;
	logic [3:0]  address = 4'h0, byteenable = 4'h0;
	logic [31:0] writedata = 32'h0, readdata, q;
	logic [23:0] cfg_word_in = 24'h004305;
	logic        waitrequest, osc_run = 1'b1, tmr = 1'b0, nopwrt = 1'b1;
	logic        sysclk = 1'b1, stall = 1'b0, fail_cmd = 1'b0;
	logic        ost = 1'b1, pll_on = 1'b0;
	logic        clk_fail_in, pll_locked_in, switch_done_in, switch_active;
	logic        secondary_osc_enable, fail_safe_monitor, switch_allowed;
	logic        div_tick, clock_fail_trap, core_run;
	logic [2:0]  current_group, target_group;
	logic [3:0]  primary_option_config, rc_trim_code;
	int          err_total = 0, checks_done = 0, cyc = 0, n;

	// 25 MHz clock and a hang cap
	always #20 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			err_total++;
			close_out();
		end
	end

	oss_ctrl u_oss_ctrl (.clk(clk), .rst(rst), .address(address),
		.read(read), .write(write), .writedata(writedata),
		.byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .cfg_word_in(cfg_word_in),
		.clk_fail_in(clk_fail_in), .osc_running_in(osc_run),
		.ost_expired_in(ost), .pll_locked_in(pll_locked_in),
		.timers_done_in(tmr), .power_up_timer_disabled_in(nopwrt),
		.sysclk_running_in(sysclk), .switch_done_in(switch_done_in),
		.current_group(current_group), .target_group(target_group),
		.switch_active(switch_active),
		.primary_option_config(primary_option_config),
		.rc_trim_code(rc_trim_code),
		.secondary_osc_enable(secondary_osc_enable),
		.fail_safe_monitor(fail_safe_monitor),
		.switch_allowed(switch_allowed), .div_tick(div_tick),
		.clock_fail_trap(clock_fail_trap), .core_run(core_run));
	oss_osc_model u_oss_osc_model (.clk(clk), .stall(stall),
		.fail_cmd(fail_cmd), .pll_on(pll_on),
		.switch_active(switch_active),
		.current_group(current_group), .switch_done_in(switch_done_in),
		.pll_locked_in(pll_locked_in), .clk_fail_in(clk_fail_in));

	// Verdict and end of run
	task automatic close_out();
		$display("errors %0d checks %0d", err_total, checks_done);
		if (err_total == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : close_out
	// One comparison
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	// One Avalon transfer, held until waitrequest is sampled low
	task automatic bus(input logic [3:0] a, input logic w,
		input logic [31:0] d, input logic [3:0] be);
		address <= a;
		read <= !w;
		write <= w;
		writedata <= d;
		byteenable <= be;
		@(posedge clk);
		while (waitrequest !== 1'b0)
			@(posedge clk);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		@(posedge clk);
	endtask : bus
	task automatic rdchk(input logic [3:0] a, input string nm,
		input logic [31:0] e);
		bus(a, 1'b0, 32'h0, 4'hf);
		chk(nm, e, q);
	endtask : rdchk
	// Keyed write of one control byte lane
	task automatic ctl(input logic hi, input logic [7:0] v);
		logic [3:0] be;
		be = hi ? 4'h2 : 4'h1;
		bus(4'h0, 1'b1, hi ? 32'h7800 : 32'h46, be);
		bus(4'h0, 1'b1, hi ? 32'h9a00 : 32'h57, be);
		bus(4'h0, 1'b1, hi ? {16'h0, v, 8'h0} : {24'h0, v}, be);
	endtask : ctl
	task automatic do_reset(input logic [23:0] c);
		rst <= 1'b1;
		cfg_word_in <= c;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
	endtask : do_reset
	// Bounded wait for a switch to start and finish
	task automatic settle();
		for (n = 0; n < 100 && switch_active !== 1'b1; n++)
			@(posedge clk);
		for (n = 0; n < 100 && switch_active !== 1'b0; n++)
			@(posedge clk);
		repeat (8) @(posedge clk);
	endtask : settle

	task automatic t_reset();
		do_reset(24'h004305);
		rdchk(4'h0, "ctrl", 32'h3300);
		rdchk(4'h8, "cfg", 32'h4305);
		rdchk(4'hc, "unmapped", 32'h0);
		chk("prim", 32'h5, 32'(primary_option_config));
		chk("modes", 32'h1, 32'({fail_safe_monitor, switch_allowed}));
		bus(4'h0, 1'b1, 32'hc3, 4'h1);
		rdchk(4'h0, "locked", 32'h3300);
		chk("fast exit", 32'h1, 32'(core_run));
		sysclk <= 1'b0;
		repeat (6) @(posedge clk);
		chk("halted", 32'h0, 32'(core_run));
		sysclk <= 1'b1;
		bus(4'h4, 1'b1, 32'hfffffff8, 4'hf);
		rdchk(4'h4, "tune", 32'h8);
		chk("trim", 32'h8, 32'(rc_trim_code));
	endtask : t_reset
	task automatic t_post();
		for (int c = 0; c < 4; c++) begin
			ctl(1'b0, 8'(c << 6));
			repeat (70) @(posedge clk);
			for (n = 0; n < 100 && div_tick !== 1'b1; n++)
				@(posedge clk);
			n = 0;
			do begin
				@(posedge clk);
				n++;
			end while (div_tick !== 1'b1 && n < 100);
			chk("period", 32'(1 << (2 * c)), 32'(n));
		end
		ctl(1'b0, 8'h02);
		chk("sec", 32'h1, 32'(secondary_osc_enable));
		ctl(1'b0, 8'h00);
	endtask : t_post
	task automatic t_switch();
		ctl(1'b1, 8'h07);
		chk("target", 32'h7, 32'(target_group));
		ctl(1'b0, 8'h01);
		settle();
		rdchk(4'h0, "to pll", 32'h7720);
		chk("cur pin", 32'h7, 32'(current_group));
		ctl(1'b0, 8'h01);
		repeat (4) @(posedge clk);
		rdchk(4'h0, "redundant", 32'h7720);
		ctl(1'b1, 8'h01);
		stall <= 1'b1;
		ctl(1'b0, 8'h01);
		@(posedge clk);
		chk("open", 32'h1, 32'(switch_active));
		ctl(1'b0, 8'h00);
		repeat (3) @(posedge clk);
		chk("aborted", 32'h0, 32'(switch_active));
		stall <= 1'b0;
		pll_on <= 1'b1;
		ctl(1'b0, 8'h01);
		settle();
		rdchk(4'h0, "to frc", 32'h1100);
		pll_on <= 1'b0;
	endtask : t_switch
	task automatic t_fail();
		do_reset(24'h000305);
		tmr <= 1'b1;
		repeat (10) @(posedge clk);
		fail_cmd <= 1'b1;
		for (n = 0; n < 20 && clock_fail_trap !== 1'b1; n++)
			@(posedge clk);
		chk("trap", 32'h1, 32'(clock_fail_trap));
		fail_cmd <= 1'b0;
		rdchk(4'h0, "failed", 32'h1308);
		ctl(1'b0, 8'h00);
		rdchk(4'h0, "cf clear", 32'h1300);
		osc_run <= 1'b0;
		do_reset(24'h000305);
		for (n = 0; n < 20 && clock_fail_trap !== 1'b1; n++)
			@(posedge clk);
		osc_run <= 1'b1;
		rdchk(4'h0, "slow start", 32'h1308);
		ost <= 1'b0;
		do_reset(24'h000305);
		for (n = 0; n < 20 && clock_fail_trap !== 1'b1; n++)
			@(posedge clk);
		ost <= 1'b1;
		rdchk(4'h0, "no ost", 32'h1308);
		do_reset(24'h008305);
		ctl(1'b1, 8'h07);
		ctl(1'b0, 8'h01);
		repeat (10) @(posedge clk);
		rdchk(4'h0, "no switch", 32'h3701);
		chk("sw off", 32'h0, 32'(switch_allowed));
	endtask : t_fail

	initial begin
		t_reset();
		t_post();
		t_switch();
		t_fail();
		close_out();
	end
endmodule : oss_ctrl_test

//--- sim/oss_osc_model.sv
// Purpose: Oscillator and PLL stand-in facing the clock switch block
// Assumes: a switch settles DONE_WAIT + 1 clocks after switch_active rises
// Notes:   stall keeps a switch open so that it can be aborted
`timescale 1ns/1ps
module oss_osc_model #(
	parameter int DONE_WAIT = 6
) (
	// Clock and bench commands
	input  wire logic       clk,
	input  wire logic       stall,
	input  wire logic       fail_cmd,
	input  wire logic       pll_on,
	// From the block
	input  wire logic       switch_active,
	input  wire logic [2:0] current_group,
	// Oscillator status
	output logic            switch_done_in,
	output logic            pll_locked_in,
	output logic            clk_fail_in
);
	int cnt = 0;
	initial {switch_done_in, pll_locked_in, clk_fail_in} = 3'h0;
	// Done drops with switch_active, so each switch sees a fresh rise
	always @(posedge clk) begin
		cnt <= switch_active ? cnt + 1 : 0;
		switch_done_in <= switch_active && !stall && cnt >= DONE_WAIT;
		pll_locked_in <= pll_on || current_group == oss_pkg::GRP_PLL;
		clk_fail_in <= fail_cmd;
	end
endmodule : oss_osc_model
